// ---- shared/sbc_pkg.sv ----
// Constants, timing counts and state encodings for the bank command tracker
package sbc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PRECHARGE_TIME_NS = 20;
  localparam int unsigned ACTIVATE_TO_ACCESS_TIME_NS = 20;
  localparam int unsigned REFRESH_CYCLE_TIME_NS = 66;
  localparam int unsigned MODE_LOAD_TIME_NS = 20;
  localparam int unsigned SELF_REFRESH_EXIT_TIME_NS = 75;
  localparam int unsigned BURST_CYCLES = 4;

  // Least times round up to whole cycles
  localparam int unsigned PRE_CYC =
    (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCD_CYC =
    (ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RFC_CYC =
    (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MRD_CYC =
    (MODE_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned XSR_CYC =
    (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Counter widths and load values
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W = 8;
  localparam int unsigned BANKS = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;
  localparam logic [CNT_W-1:0] PRE_CNT = CNT_W'(PRE_CYC);
  localparam logic [CNT_W-1:0] RCD_CNT = CNT_W'(RCD_CYC);
  localparam logic [CNT_W-1:0] RFC_CNT = CNT_W'(RFC_CYC);
  localparam logic [CNT_W-1:0] MRD_CNT = CNT_W'(MRD_CYC);
  localparam logic [CNT_W-1:0] XSR_CNT = CNT_W'(XSR_CYC);
  localparam logic [CNT_W-1:0] BURST_CNT = CNT_W'(BURST_CYCLES);
  localparam logic [CNT_W-1:0] AP_CNT = CNT_W'(BURST_CYCLES + PRE_CYC);

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_READ = 4'h3,
    CMD_WRITE = 4'h4, CMD_PRE = 4'h5, CMD_STOP = 4'h6, CMD_REF = 4'h7,
    CMD_MODE = 4'h8
  } sbc_cmd_t;

  typedef enum logic [7:0] {
    BK_IDLE = 8'h01, BK_ACTIVATING = 8'h02, BK_ACTIVE = 8'h04,
    BK_READ = 8'h08, BK_WRITE = 8'h10, BK_READ_AP = 8'h20,
    BK_WRITE_AP = 8'h40, BK_PRECHARGING = 8'h80
  } sbc_bank_t;

  typedef enum logic [5:0] {
    DV_NORMAL = 6'h01, DV_REFRESH = 6'h02, DV_MODE = 6'h04,
    DV_PRE_ALL = 6'h08, DV_SELF_REF = 6'h10, DV_SR_EXIT = 6'h20
  } sbc_dev_t;

endpackage : sbc_pkg

// ---- logic/sbc_cmd_dec.sv ----
// Decoder from the four command strobes to a command code
`timescale 1ns/1ps
`default_nettype none
module sbc_cmd_dec (
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  output sbc_pkg::sbc_cmd_t cmd
);

  // Deselect overrides every other strobe
  always_comb begin
    if (cs_n) begin
      cmd = sbc_pkg::CMD_INHIBIT;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: cmd = sbc_pkg::CMD_NOP;
        3'h3: cmd = sbc_pkg::CMD_ACT;
        3'h5: cmd = sbc_pkg::CMD_READ;
        3'h4: cmd = sbc_pkg::CMD_WRITE;
        3'h2: cmd = sbc_pkg::CMD_PRE;
        3'h6: cmd = sbc_pkg::CMD_STOP;
        3'h1: cmd = sbc_pkg::CMD_REF;
        3'h0: cmd = sbc_pkg::CMD_MODE;
      endcase
    end
  end

endmodule : sbc_cmd_dec
`default_nettype wire

// ---- logic/sbc_timer.sv ----
// Loadable down counter that flags the last cycle of a timed state
`timescale 1ns/1ps
`default_nettype none
module sbc_timer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic load,
  input wire logic [sbc_pkg::CNT_W-1:0] load_val,
  output logic done
);

  logic [sbc_pkg::CNT_W-1:0] cnt_ff;
  logic [sbc_pkg::CNT_W-1:0] nxt_cnt;

  // A load restarts the count; otherwise count down and rest at zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != sbc_pkg::CNT_ZERO) begin
      nxt_cnt = cnt_ff - sbc_pkg::CNT_LAST;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_ff <= sbc_pkg::CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Last cycle of the timed interval
  assign done = (cnt_ff == sbc_pkg::CNT_LAST);

endmodule : sbc_timer
`default_nettype wire

// ---- logic/sbc_bank_fsm.sv ----
// Four-bank command tracker with device-wide refresh and mode states
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Deselected edge is ignored; work in progress carries on.
// - No-operation leaves every bank's activity untouched.
// - Activate opens a row, only in an idle bank.
// - Refresh and mode load are device-wide; all banks must be idle.
// - Precharge to an idle bank changes nothing.
// - Row active bank takes read and write, with or without auto precharge.
// - In a plain burst, read or write restarts; precharge truncates it.
// - Burst stop cuts the most recent read or write burst, any bank.
// - Decoding only with clock gate high twice and after self refresh exit.
// - Bank is idle only once precharge time has passed.
// - Row active follows activate plus activate-to-access time.
// - Row activating lasts activate-to-access time, then row active.
// - Auto precharge access holds bank busy through precharge, then idle.
// - Refreshing lasts refresh cycle time, then all banks idle.
// - Mode access lasts mode-load time, then all banks idle.
// - Precharge all lasts precharge time, leaving all banks idle.
// - An idle bank never restricts commands to other banks.
// - Activating, active or precharging bank allows others any access.
// - Read or write to another bank interrupts the running burst.
// - Interrupted auto precharge burst starts its precharge at once.
// - Address bit high on read or write selects auto precharge.
// - Address bit high on precharge means all banks, ignore bank select.
module sbc_bank_fsm (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic AUTO_PRECHARGE_ADDR_BIT,
  input wire logic BANK_SELECT_LO,
  input wire logic BANK_SELECT_HI,
  output logic [8*sbc_pkg::BANKS-1:0] BANK_STATE,
  output logic [5:0] DEV_STATE,
  output logic [1:0] LAST_BURST_BANK,
  output logic ILLEGAL_CMD
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Any of the four burst states
  function automatic logic in_burst(input sbc_pkg::sbc_bank_t st);
    in_burst = (st == sbc_pkg::BK_READ) || (st == sbc_pkg::BK_WRITE) ||
               (st == sbc_pkg::BK_READ_AP) || (st == sbc_pkg::BK_WRITE_AP);
  endfunction : in_burst

  // Auto precharge burst states
  function automatic logic in_ap(input sbc_pkg::sbc_bank_t st);
    in_ap = (st == sbc_pkg::BK_READ_AP) || (st == sbc_pkg::BK_WRITE_AP);
  endfunction : in_ap

  // States with an open row that accept column access
  function automatic logic row_open(input sbc_pkg::sbc_bank_t st);
    row_open = (st == sbc_pkg::BK_ACTIVE) || (st == sbc_pkg::BK_READ) ||
               (st == sbc_pkg::BK_WRITE);
  endfunction : row_open

  // ----------------------------------------------------------------------
  // Command decode and gating
  // ----------------------------------------------------------------------
  sbc_pkg::sbc_cmd_t cmd;
  sbc_pkg::sbc_bank_t bank_st_ff [sbc_pkg::BANKS];
  sbc_pkg::sbc_bank_t nxt_bank_st [sbc_pkg::BANKS];
  sbc_pkg::sbc_dev_t dev_ff;
  sbc_pkg::sbc_dev_t nxt_dev;
  logic cke_prev_ff;
  logic [1:0] last_bank_ff;
  logic [1:0] nxt_last_bank;
  logic illegal_ff;
  logic nxt_illegal;
  logic [1:0] tgt;
  logic dec_en;
  logic all_idle;
  logic rdwr;
  logic [sbc_pkg::BANKS-1:0] bank_ld;
  logic [sbc_pkg::BANKS-1:0] bank_done;
  logic [sbc_pkg::BANKS-1:0] bank_ill;
  logic [sbc_pkg::BANKS-1:0] bank_idle;
  logic [sbc_pkg::CNT_W-1:0] bank_lv [sbc_pkg::BANKS];
  logic dev_ld;
  logic dev_done;
  logic [sbc_pkg::CNT_W-1:0] dev_lv;

  sbc_cmd_dec u_dec (
    .cs_n(CS_N),
    .ras_n(RAS_N),
    .cas_n(CAS_N),
    .we_n(WE_N),
    .cmd(cmd)
  );

  // Clock gate high on both edges and no device-wide operation running;
  // busy device states simply ignore the strobes
  assign dec_en = cke_prev_ff && CKE && (dev_ff == sbc_pkg::DV_NORMAL);
  assign tgt = {BANK_SELECT_HI, BANK_SELECT_LO};
  assign rdwr = (cmd == sbc_pkg::CMD_READ) || (cmd == sbc_pkg::CMD_WRITE);
  assign all_idle = &bank_idle;

  // ----------------------------------------------------------------------
  // Per-bank state machines
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < sbc_pkg::BANKS; i++) begin : g_bank
    logic own;

    assign own = (tgt == 2'(i));
    assign bank_idle[i] = (bank_st_ff[i] == sbc_pkg::BK_IDLE);

    sbc_timer u_tmr (
      .CLK(CLK),
      .RST_N(RST_N),
      .load(bank_ld[i]),
      .load_val(bank_lv[i]),
      .done(bank_done[i])
    );

    // Timer expiry first, then a registered command may override it
    always_comb begin
      nxt_bank_st[i] = bank_st_ff[i];
      bank_ld[i] = 1'b0;
      bank_lv[i] = sbc_pkg::CNT_ZERO;
      bank_ill[i] = 1'b0;
      if (bank_done[i]) begin
        unique case (bank_st_ff[i])
          sbc_pkg::BK_ACTIVATING: nxt_bank_st[i] = sbc_pkg::BK_ACTIVE;
          sbc_pkg::BK_READ, sbc_pkg::BK_WRITE: begin
            nxt_bank_st[i] = sbc_pkg::BK_ACTIVE;
          end
          sbc_pkg::BK_READ_AP, sbc_pkg::BK_WRITE_AP: begin
            nxt_bank_st[i] = sbc_pkg::BK_IDLE;
          end
          sbc_pkg::BK_PRECHARGING: nxt_bank_st[i] = sbc_pkg::BK_IDLE;
          default: nxt_bank_st[i] = bank_st_ff[i];
        endcase
      end
      if (dec_en) begin
        if (cmd == sbc_pkg::CMD_PRE && (AUTO_PRECHARGE_ADDR_BIT || own)) begin
          // Idle bank is left alone; all-bank form ignores bank select
          if (own && !AUTO_PRECHARGE_ADDR_BIT && !row_open(bank_st_ff[i]) &&
              !bank_idle[i]) begin
            bank_ill[i] = 1'b1;
          end else if (!bank_idle[i]) begin
            nxt_bank_st[i] = sbc_pkg::BK_PRECHARGING;
            bank_ld[i] = 1'b1;
            bank_lv[i] = sbc_pkg::PRE_CNT;
          end
        end else if (cmd == sbc_pkg::CMD_ACT && own) begin
          if (bank_idle[i]) begin
            nxt_bank_st[i] = sbc_pkg::BK_ACTIVATING;
            bank_ld[i] = 1'b1;
            bank_lv[i] = sbc_pkg::RCD_CNT;
          end else begin
            bank_ill[i] = 1'b1;
          end
        end else if (rdwr && own) begin
          if (row_open(bank_st_ff[i])) begin
            bank_ld[i] = 1'b1;
            bank_lv[i] = AUTO_PRECHARGE_ADDR_BIT ? sbc_pkg::AP_CNT :
                                                   sbc_pkg::BURST_CNT;
            if (cmd == sbc_pkg::CMD_READ) begin
              nxt_bank_st[i] = AUTO_PRECHARGE_ADDR_BIT ?
                sbc_pkg::BK_READ_AP : sbc_pkg::BK_READ;
            end else begin
              nxt_bank_st[i] = AUTO_PRECHARGE_ADDR_BIT ?
                sbc_pkg::BK_WRITE_AP : sbc_pkg::BK_WRITE;
            end
          end else begin
            bank_ill[i] = 1'b1;
          end
        end else if ((rdwr && !own) ||
                     (cmd == sbc_pkg::CMD_STOP && last_bank_ff == 2'(i))) begin
          // Interrupt by another bank's burst, or burst stop on this one
          if (in_ap(bank_st_ff[i])) begin
            nxt_bank_st[i] = sbc_pkg::BK_PRECHARGING;
            bank_ld[i] = 1'b1;
            bank_lv[i] = sbc_pkg::PRE_CNT;
          end else if (in_burst(bank_st_ff[i])) begin
            nxt_bank_st[i] = sbc_pkg::BK_ACTIVE;
          end
        end
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        bank_st_ff[i] <= sbc_pkg::BK_IDLE;
      end else begin
        bank_st_ff[i] <= nxt_bank_st[i];
      end
    end

    assign BANK_STATE[8*i +: 8] = bank_st_ff[i];

    // Checks for this bank
    sequence s_act_here;
      dec_en && cmd == sbc_pkg::CMD_ACT && own && bank_idle[i];
    endsequence

    a_act_opens_row: assert property (@(posedge CLK) disable iff (!RST_N)
      s_act_here |=> bank_st_ff[i] == sbc_pkg::BK_ACTIVATING
                     ##2 bank_st_ff[i] == sbc_pkg::BK_ACTIVE)
      else $error("activate did not reach row active after two cycles");

    a_pre_idle_noop: assert property (@(posedge CLK) disable iff (!RST_N)
      dec_en && cmd == sbc_pkg::CMD_PRE && own && bank_idle[i]
      |=> bank_idle[i])
      else $error("precharge disturbed an idle bank");

    a_read_plain: assert property (@(posedge CLK) disable iff (!RST_N)
      dec_en && cmd == sbc_pkg::CMD_READ && own && !AUTO_PRECHARGE_ADDR_BIT &&
      row_open(bank_st_ff[i]) |=> bank_st_ff[i] == sbc_pkg::BK_READ)
      else $error("plain read did not enter read state");

    a_read_ap_sel: assert property (@(posedge CLK) disable iff (!RST_N)
      dec_en && cmd == sbc_pkg::CMD_READ && own && AUTO_PRECHARGE_ADDR_BIT &&
      row_open(bank_st_ff[i]) |=> bank_st_ff[i] == sbc_pkg::BK_READ_AP)
      else $error("auto precharge bit ignored on read");

    a_pre_truncate: assert property (@(posedge CLK) disable iff (!RST_N)
      dec_en && cmd == sbc_pkg::CMD_PRE && own &&
      (bank_st_ff[i] == sbc_pkg::BK_WRITE) |=>
      bank_st_ff[i] == sbc_pkg::BK_PRECHARGING ##2 bank_idle[i])
      else $error("precharge did not truncate write burst");

    a_ap_interrupt: assert property (@(posedge CLK) disable iff (!RST_N)
      dec_en && rdwr && !own && in_ap(bank_st_ff[i]) |=>
      bank_st_ff[i] == sbc_pkg::BK_PRECHARGING)
      else $error("interrupted auto precharge burst did not precharge");

    a_nop_holds: assert property (@(posedge CLK) disable iff (!RST_N)
      cmd == sbc_pkg::CMD_NOP && bank_st_ff[i] == sbc_pkg::BK_ACTIVE
      |=> bank_st_ff[i] == sbc_pkg::BK_ACTIVE)
      else $error("no-operation changed an active bank");
  end

  // ----------------------------------------------------------------------
  // Device-wide state
  // ----------------------------------------------------------------------
  sbc_timer u_dev_tmr (
    .CLK(CLK),
    .RST_N(RST_N),
    .load(dev_ld),
    .load_val(dev_lv),
    .done(dev_done)
  );

  // Refresh, mode load and precharge all hold off all decoding until done
  always_comb begin
    nxt_dev = dev_ff;
    dev_ld = 1'b0;
    dev_lv = sbc_pkg::CNT_ZERO;
    unique case (dev_ff)
      sbc_pkg::DV_NORMAL: begin
        if (cke_prev_ff && !CKE && cmd == sbc_pkg::CMD_REF && all_idle) begin
          nxt_dev = sbc_pkg::DV_SELF_REF;
        end else if (dec_en && cmd == sbc_pkg::CMD_REF && all_idle) begin
          nxt_dev = sbc_pkg::DV_REFRESH;
          dev_ld = 1'b1;
          dev_lv = sbc_pkg::RFC_CNT;
        end else if (dec_en && cmd == sbc_pkg::CMD_MODE && all_idle) begin
          nxt_dev = sbc_pkg::DV_MODE;
          dev_ld = 1'b1;
          dev_lv = sbc_pkg::MRD_CNT;
        end else if (dec_en && cmd == sbc_pkg::CMD_PRE &&
                     AUTO_PRECHARGE_ADDR_BIT) begin
          nxt_dev = sbc_pkg::DV_PRE_ALL;
          dev_ld = 1'b1;
          dev_lv = sbc_pkg::PRE_CNT;
        end
      end
      sbc_pkg::DV_REFRESH, sbc_pkg::DV_MODE, sbc_pkg::DV_PRE_ALL: begin
        if (dev_done) begin
          nxt_dev = sbc_pkg::DV_NORMAL;
        end
      end
      sbc_pkg::DV_SELF_REF: begin
        if (CKE) begin
          nxt_dev = sbc_pkg::DV_SR_EXIT;
          dev_ld = 1'b1;
          dev_lv = sbc_pkg::XSR_CNT;
        end
      end
      sbc_pkg::DV_SR_EXIT: begin
        if (dev_done) begin
          nxt_dev = sbc_pkg::DV_NORMAL;
        end
      end
      default: nxt_dev = sbc_pkg::DV_NORMAL;
    endcase
  end

  // Burst ownership and misuse flag
  always_comb begin
    nxt_last_bank = last_bank_ff;
    nxt_illegal = |bank_ill;
    if (dec_en && rdwr) begin
      nxt_last_bank = tgt;
    end
    if (dec_en && (cmd == sbc_pkg::CMD_REF || cmd == sbc_pkg::CMD_MODE) &&
        !all_idle) begin
      nxt_illegal = 1'b1;
    end
    if (dec_en && cmd == sbc_pkg::CMD_STOP &&
        !in_burst(bank_st_ff[last_bank_ff])) begin
      nxt_illegal = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dev_ff <= sbc_pkg::DV_NORMAL;
      cke_prev_ff <= 1'b0;
      last_bank_ff <= 2'h0;
      illegal_ff <= 1'b0;
    end else begin
      dev_ff <= nxt_dev;
      cke_prev_ff <= CKE;
      last_bank_ff <= nxt_last_bank;
      illegal_ff <= nxt_illegal;
    end
  end

  assign DEV_STATE = dev_ff;
  assign LAST_BURST_BANK = last_bank_ff;
  assign ILLEGAL_CMD = illegal_ff;

  // ----------------------------------------------------------------------
  // Device-level checks
  // ----------------------------------------------------------------------
  sequence s_refresh_run;
    (dev_ff == sbc_pkg::DV_REFRESH) [*7];
  endsequence

  a_refresh_length: assert property (@(posedge CLK) disable iff (!RST_N)
    dec_en && cmd == sbc_pkg::CMD_REF && all_idle |=>
    s_refresh_run ##1 dev_ff == sbc_pkg::DV_NORMAL)
    else $error("refresh did not last the refresh cycle time");

  a_inhibit_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
    CS_N |=> $stable(last_bank_ff) && !illegal_ff)
    else $error("deselected edge changed the decoder");

  a_stop_last_burst: assert property (@(posedge CLK) disable iff (!RST_N)
    dec_en && cmd == sbc_pkg::CMD_STOP &&
    bank_st_ff[last_bank_ff] == sbc_pkg::BK_READ |=>
    bank_st_ff[$past(last_bank_ff)] == sbc_pkg::BK_ACTIVE)
    else $error("burst stop did not end the latest read");

  a_gate_low_blocks: assert property (@(posedge CLK) disable iff (!RST_N)
    !cke_prev_ff && CKE && cmd == sbc_pkg::CMD_MODE &&
    dev_ff == sbc_pkg::DV_NORMAL |=> dev_ff == sbc_pkg::DV_NORMAL)
    else $error("command decoded while clock gate was low");

endmodule : sbc_bank_fsm
`default_nettype wire

// ---- verification/sbc_ctrl_model.sv ----
// Memory controller model that drives commands on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module sbc_ctrl_model (
  output logic CKE,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic AUTO_PRECHARGE_ADDR_BIT,
  output logic BANK_SELECT_LO,
  output logic BANK_SELECT_HI,
  input wire logic CLK
);
  int seed = 32'hdbdb;
  logic cke_lvl = 1'b1;

  // One seed for the whole run keeps every failure reproducible
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction : rnd

  // Deselected with the clock gate open from time zero
  initial begin
    CKE = 1'b1;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
    {BANK_SELECT_HI, BANK_SELECT_LO, AUTO_PRECHARGE_ADDR_BIT} = 3'h0;
  end

  // One command per edge, strobe pattern chosen by command code
  task automatic send(input sbc_pkg::sbc_cmd_t c, input logic [1:0] b,
                      input logic ap);
    logic [3:0] s;
    case (c)
      sbc_pkg::CMD_INHIBIT: s = {1'b1, 3'(rnd())};
      sbc_pkg::CMD_NOP: s = 4'h7;
      sbc_pkg::CMD_ACT: s = 4'h3;
      sbc_pkg::CMD_REF: s = 4'h1;
      sbc_pkg::CMD_MODE: s = 4'h0;
      sbc_pkg::CMD_PRE: s = 4'h2;
      sbc_pkg::CMD_READ: s = 4'h5;
      sbc_pkg::CMD_WRITE: s = 4'h4;
      default: s = 4'h6;
    endcase
    @(negedge CLK);
    CKE = cke_lvl;
    {CS_N, RAS_N, CAS_N, WE_N} = s;
    {BANK_SELECT_HI, BANK_SELECT_LO} = b;
    AUTO_PRECHARGE_ADDR_BIT = ap;
  endtask : send

  // Waiting edges carry changing address bits so stale values never match
  task automatic idle(input int n);
    repeat (n) send(sbc_pkg::CMD_NOP, 2'(rnd()), 1'(rnd()));
  endtask : idle
endmodule : sbc_ctrl_model
`default_nettype wire

// ---- verification/sbc_bank_fsm_tb.sv ----
// Self-checking bench for the four-bank command tracker
`timescale 1ns/1ps
`default_nettype none
module sbc_bank_fsm_tb;
  localparam int PRE = sbc_pkg::PRE_CYC;
  localparam int RCD = sbc_pkg::RCD_CYC;
  localparam int RFC = sbc_pkg::RFC_CYC;
  localparam int MRD = sbc_pkg::MRD_CYC;
  localparam int BUR = sbc_pkg::BURST_CYCLES;
  localparam int AP = BUR + PRE;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, ap_bit, bs_lo, bs_hi;
  logic [31:0] bank_state;
  logic [5:0] dev_state;
  logic [1:0] last_bank;
  logic illegal;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] st [4];
  int cnt [4];
  logic [5:0] dv;
  int dcnt;
  logic [1:0] lb;
  logic ill, ckp;

  // 100 MHz clock
  always #5 clk = ~clk;

  sbc_ctrl_model ctrl (.CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .AUTO_PRECHARGE_ADDR_BIT(ap_bit),
    .BANK_SELECT_LO(bs_lo), .BANK_SELECT_HI(bs_hi), .CLK(clk));

  sbc_bank_fsm i_sbc_bank_fsm (.CLK(clk), .RST_N(rst_n), .CKE(cke),
    .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
    .AUTO_PRECHARGE_ADDR_BIT(ap_bit), .BANK_SELECT_LO(bs_lo),
    .BANK_SELECT_HI(bs_hi), .BANK_STATE(bank_state),
    .DEV_STATE(dev_state), .LAST_BURST_BANK(last_bank),
    .ILLEGAL_CMD(illegal));

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  task automatic put(input int k, input logic [7:0] s, input int n);
    st[k] = s;
    cnt[k] = n;
  endtask : put

  // Timers step first; a command on the same edge overrides them
  always @(posedge clk or negedge rst_n) begin : model
    logic [7:0] o [4];
    logic [5:0] od;
    int b;
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) put(i, 8'h01, 0);
      dv = 6'h01;
      dcnt = 0;
      lb = 2'h0;
      ill = 1'b0;
      ckp = 1'b0;
    end else begin
      o = st;
      od = dv;
      ill = 1'b0;
      b = {bs_hi, bs_lo};
      for (int i = 0; i < 4; i++) begin
        if (o[i] != 8'h01 && o[i] != 8'h04) begin
          if (cnt[i] == 1) st[i] = (o[i] > 8'h10) ? 8'h01 : 8'h04;
          else cnt[i]--;
        end
      end
      if (od != 6'h01) begin
        if (dcnt == 1) dv = 6'h01;
        else dcnt--;
      end
      if (ckp && cke && od == 6'h01 && !cs_n) begin
        case ({ras_n, cas_n, we_n})
          3'h3: begin
            if (o[b] == 8'h01) put(b, 8'h02, RCD);
            else ill = 1'b1;
          end
          3'h5, 3'h4: begin
            if (o[b] inside {8'h04, 8'h08, 8'h10}) begin
              for (int n = 0; n < 4; n++) begin
                if (n != b && o[n] inside {8'h08, 8'h10}) st[n] = 8'h04;
                if (n != b && o[n] inside {8'h20, 8'h40}) put(n, 8'h80, PRE);
              end
              if (ap_bit) put(b, we_n ? 8'h20 : 8'h40, AP);
              else put(b, we_n ? 8'h08 : 8'h10, BUR);
              lb = 2'(b);
            end else ill = 1'b1;
          end
          3'h2: begin
            if (ap_bit) begin
              dv = 6'h08;
              dcnt = PRE;
              for (int n = 0; n < 4; n++) if (o[n] != 8'h01) put(n, 8'h80, PRE);
            end else if (o[b] inside {8'h04, 8'h08, 8'h10}) put(b, 8'h80, PRE);
            else if (o[b] != 8'h01) ill = 1'b1;
          end
          3'h6: begin
            if (o[lb] inside {8'h08, 8'h10}) st[lb] = 8'h04;
            else if (o[lb] inside {8'h20, 8'h40}) put(lb, 8'h80, PRE);
            else ill = 1'b1;
          end
          3'h1, 3'h0: begin
            if ({o[0], o[1], o[2], o[3]} == 32'h01010101) begin
              dv = we_n ? 6'h02 : 6'h04;
              dcnt = we_n ? RFC : MRD;
            end else ill = 1'b1;
          end
          default: ;
        endcase
      end
      ckp = cke;
    end
  end

  // ----------------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h wanted %h", $time, what, seen,
               exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Outputs are settled half a cycle after the edge that moved them
  always @(negedge clk) begin
    if (rst_n) begin
      chk(bank_state, {st[3], st[2], st[1], st[0]}, "banks");
      chk(32'(dev_state), 32'(dv), "device");
      chk(32'(last_bank), 32'(lb), "last burst");
      chk(32'(illegal), 32'(ill), "refusal");
    end
  end

  // Hang guard: an overlong run counts against the design
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // Directed sequences, then random open/access/close rounds
  initial begin
    logic [1:0] b;
    logic a, w;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    ctrl.idle(2);
    ctrl.cke_lvl = 1'b0;
    ctrl.send(sbc_pkg::CMD_ACT, 2'h0, 1'b0);
    ctrl.cke_lvl = 1'b1;
    ctrl.send(sbc_pkg::CMD_ACT, 2'h0, 1'b0);
    ctrl.idle(2);
    $display("test clock gate done");
    ctrl.send(sbc_pkg::CMD_ACT, 2'h1, 1'b0);
    ctrl.idle(RCD);
    ctrl.send(sbc_pkg::CMD_READ, 2'h1, 1'b0);
    ctrl.idle(1);
    ctrl.send(sbc_pkg::CMD_READ, 2'h1, 1'b0);
    ctrl.idle(1);
    ctrl.send(sbc_pkg::CMD_STOP, 2'h3, 1'b0);
    ctrl.send(sbc_pkg::CMD_WRITE, 2'h1, 1'b0);
    ctrl.idle(BUR);
    ctrl.send(sbc_pkg::CMD_STOP, 2'h2, 1'b0);
    $display("test bursts done");
    ctrl.send(sbc_pkg::CMD_ACT, 2'h0, 1'b0);
    ctrl.send(sbc_pkg::CMD_ACT, 2'h2, 1'b0);
    ctrl.idle(RCD - 1);
    ctrl.send(sbc_pkg::CMD_READ, 2'h0, 1'b1);
    ctrl.send(sbc_pkg::CMD_WRITE, 2'h2, 1'b0);
    ctrl.send(sbc_pkg::CMD_PRE, 2'h3, 1'b0);
    ctrl.send(sbc_pkg::CMD_PRE, 2'h2, 1'b0);
    ctrl.send(sbc_pkg::CMD_ACT, 2'h1, 1'b0);
    ctrl.idle(AP);
    ctrl.send(sbc_pkg::CMD_REF, 2'h0, 1'b0);
    ctrl.send(sbc_pkg::CMD_PRE, 2'(ctrl.rnd()), 1'b1);
    ctrl.idle(PRE);
    ctrl.send(sbc_pkg::CMD_REF, 2'h0, 1'b0);
    repeat (RFC) ctrl.send(sbc_pkg::CMD_INHIBIT, 2'h1, 1'b0);
    ctrl.send(sbc_pkg::CMD_MODE, 2'h0, 1'b0);
    ctrl.idle(MRD + 1);
    $display("test interleave done");
    for (int i = 0; i < 16; i++) begin
      b = 2'(ctrl.rnd());
      a = 1'(ctrl.rnd());
      w = 1'(ctrl.rnd());
      ctrl.send(sbc_pkg::CMD_ACT, b, 1'b0);
      ctrl.idle(RCD);
      ctrl.send(w ? sbc_pkg::CMD_WRITE : sbc_pkg::CMD_READ, b, a);
      ctrl.idle(AP);
      ctrl.send(sbc_pkg::CMD_PRE, b, 1'b0);
      ctrl.idle(PRE);
    end
    $display("test random rounds done");
    print_verdict();
  end
endmodule : sbc_bank_fsm_tb
`default_nettype wire
